// File: bench/radio_link_config_registers_tb.sv
`timescale 1ns/1ns
`default_nettype none

module radio_link_config_registers_tb;
  typedef struct packed {logic [6:0] a; logic [7:0] rst, wd, rb;} rlc_row_t;
  logic sys_clk = 0, rst_n = 0, spi_csn, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic tx_fifo_empty = 0, rx_fifo_empty = 0, sig_meas_done = 0;
  logic new_packet = 0, tx_sent = 0, ack_rcvd = 0;
  logic [2:0] rx_pipe = 3'h0;
  logic [5:0] rx_dyn_length = 6'h2A, rx_other_fixed_length = 6'h11, rx_payload_length;
  logic int_pin, air_rate_select, checksum_enable, checksum_length, resend_req;
  logic [1:0] group_address_length, output_power_level, crc_bytes;
  logic [2:0] address_bytes;
  logic [7:0] pipe_rx_enable, pipe_ack_enable, pipe_varlen_enable, rd;
  logic [3:0] resend_counter;
  int err_total = 0, samples_checked = 0, cyc = 0, n, k, w;
  // Address, reset value, write, readback
  localparam rlc_row_t ROWS[9] = '{
    '{7'h03, 8'h33, 8'hFF, 8'h7F}, '{7'h04, 8'hFF, 8'h5A, 8'h5A},
    '{7'h05, 8'h00, 8'hA5, 8'hA5}, '{7'h06, 8'h00, 8'h3C, 8'h3C},
    '{7'h07, 8'h00, 8'h9E, 8'h9E}, '{7'h08, 8'h00, 8'hF3, 8'hF0},
    '{7'h02, 8'h30, 8'h40, 8'h00}, '{7'h7F, 8'h00, 8'h55, 8'h00},
    '{7'h16, 8'h00, 8'h20, 8'h20}};

  rlc_host_model host_u (.sys_clk(sys_clk), .spi_csn(spi_csn), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));
  rlc_top #(.STEP_CYCLES(10)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .spi_csn(spi_csn),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .tx_fifo_empty(tx_fifo_empty), .rx_fifo_empty(rx_fifo_empty),
    .sig_meas_done(sig_meas_done), .new_packet(new_packet), .tx_sent(tx_sent),
    .ack_rcvd(ack_rcvd), .rx_pipe(rx_pipe), .rx_dyn_length(rx_dyn_length),
    .rx_other_fixed_length(rx_other_fixed_length), .int_pin(int_pin),
    .group_address_length(group_address_length), .address_bytes(address_bytes),
    .air_rate_select(air_rate_select), .output_power_level(output_power_level),
    .checksum_enable(checksum_enable), .checksum_length(checksum_length),
    .crc_bytes(crc_bytes), .pipe_rx_enable(pipe_rx_enable),
    .pipe_ack_enable(pipe_ack_enable), .pipe_varlen_enable(pipe_varlen_enable),
    .rx_payload_length(rx_payload_length), .resend_req(resend_req),
    .resend_counter(resend_counter));

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task end_of_test;
    if (err_total == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task step(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask : step

  task wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({1'b1, a}, d, rd);
  endtask : wr

  task rdr(input logic [6:0] a);
    host_u.xfer({1'b0, a}, 8'h00, rd);
  endtask : rdr

  task send_wait;
    tx_sent = 1'b1;
    step(1);
    tx_sent = 1'b0;
    k = 0;
    while (resend_req !== 1'b1 && k < 200) begin
      step(1);
      k++;
    end
  endtask : send_wait

  task fresh_packet;
    new_packet = 1'b1;
    step(1);
    new_packet = 1'b0;
    step(2);
  endtask : fresh_packet

  initial begin
    step(10);
    rst_n = 1'b1;
    step(1);
    check("int idle", int_pin, 8'h01);
    foreach (ROWS[i]) begin
      rdr(ROWS[i].a);
      check("reset value", rd, ROWS[i].rst);
      wr(ROWS[i].a, ROWS[i].wd);
      rdr(ROWS[i].a);
      check("readback", rd, ROWS[i].rb);
    end
    check("ack enables", pipe_ack_enable, 8'hA5);
    check("varlen enables", pipe_varlen_enable, 8'h3C);
    check("rx enables", pipe_rx_enable, 8'h5A);
    // Code 00 is never programmed
    for (n = 1; n < 4; n++) begin
      wr(7'h03, {1'b0, n[1:0], n[0], n[1:0], n[1], n[0]});
      check("address bytes", address_bytes, 8'(n + 1));
      check("rate", air_rate_select, n[0]);
      check("power", output_power_level, n[1:0]);
      check("crc bytes", crc_bytes, 8'(n - 1));
    end
    step(2);
    check("pipe1 length", rx_payload_length, 8'h20);
    rx_pipe = 3'h2;
    step(2);
    check("dynamic length", rx_payload_length, 8'h2A);
    rx_pipe = 3'h7;
    step(2);
    check("other length", rx_payload_length, 8'h11);
    tx_fifo_empty = 1'b1;
    wr(7'h02, 8'h04);
    check("int tx low", int_pin, 8'h00);
    tx_fifo_empty = 1'b0;
    step(2);
    check("int tx gone", int_pin, 8'h01);
    wr(7'h02, 8'h82);
    rx_fifo_empty = 1'b1;
    step(2);
    check("int rx high", int_pin, 8'h01);
    rx_fifo_empty = 1'b0;
    wr(7'h02, 8'h81);
    sig_meas_done = 1'b1;
    step(1);
    sig_meas_done = 1'b0;
    step(2);
    check("int meas", int_pin, 8'h01);
    rdr(7'h01);
    check("meas flag", rd, 8'h05);
    wr(7'h01, 8'h04);
    check("int cleared", int_pin, 8'h00);
    wr(7'h07, 8'h12);
    wr(7'h08, 8'h40);
    wr(7'h02, 8'h88);
    fresh_packet();
    for (n = 0; n < 5; n++) begin
      send_wait();
      w = (2 + 2 * (n % 3 + 1)) * 10;
      if (n < 4) begin
        check("resend wait", 8'((k > w - 4) && (k < w + 4)), 8'h01);
        check("resend count", resend_counter, 8'(n + 1));
      end else begin
        check("no resend", 8'(k), 8'(200));
      end
    end
    check("int limit", int_pin, 8'h01);
    rdr(7'h01);
    check("limit flag", rd, 8'h09);
    wr(7'h01, 8'h08);
    check("limit cleared", int_pin, 8'h00);
    fresh_packet();
    check("count restart", resend_counter, 8'h00);
    wr(7'h07, 8'h30);
    send_wait();
    check("zero resend delay", 8'((k > 36) && (k < 44)), 8'h01);
    tx_sent = 1'b1;
    step(1);
    tx_sent = 1'b0;
    step(5);
    ack_rcvd = 1'b1;
    step(1);
    ack_rcvd = 1'b0;
    k = 0;
    while (resend_req !== 1'b1 && k < 100) begin
      step(1);
      k++;
    end
    check("ack cancels", 8'(k), 8'(100));
    end_of_test();
  end
endmodule : radio_link_config_registers_tb

bind rlc_top rlc_props #(.STEP_CYCLES(STEP_CYCLES)) props_u (.sys_clk(sys_clk),
  .rst_n(rst_n), .new_packet(new_packet), .rx_pipe(rx_pipe), .rx_dyn_length(rx_dyn_length),
  .group_address_length(group_address_length), .address_bytes(address_bytes),
  .air_rate_select(air_rate_select), .checksum_enable(checksum_enable),
  .checksum_length(checksum_length), .crc_bytes(crc_bytes),
  .pipe_ack_enable(pipe_ack_enable), .pipe_varlen_enable(pipe_varlen_enable),
  .rx_payload_length(rx_payload_length), .resend_req(resend_req),
  .resend_counter(resend_counter));

`default_nettype wire

// File: bench/rlc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module rlc_host_model (
  input wire logic sys_clk, // System clock
  output var logic spi_csn = 1'b1, // Select
  output var logic spi_sck = 1'b0, // Serial clock
  output var logic spi_mosi = 1'b0, // Data to device
  input wire logic spi_miso, // Data from device
  input wire logic spi_miso_oe // Device drives data
);
  // One register per select, five cycles per sck phase
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, output logic [7:0] r);
    logic [15:0] sh;
    sh = {c, d};
    r = 8'h00;
    @(posedge sys_clk) #1 spi_csn = 1'b0;
    for (int i = 0; i < 16; i++) begin
      spi_mosi = sh[15-i];
      repeat (5) @(posedge sys_clk);
      #1 spi_sck = 1'b1;
      if (i >= 8) r = {r[6:0], spi_miso & spi_miso_oe};
      repeat (5) @(posedge sys_clk);
      #1 spi_sck = 1'b0;
    end
    repeat (5) @(posedge sys_clk);
    #1 spi_csn = 1'b1;
    // Released line shows no stale bit
    spi_mosi = ~spi_mosi;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : xfer
endmodule : rlc_host_model

`default_nettype wire

// File: bench/rlc_props.sv
`timescale 1ns/1ns
`default_nettype none

module rlc_props #(
  parameter int unsigned STEP_CYCLES = 10
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic new_packet, // New payload
  input wire logic [2:0] rx_pipe, // Receive pipe
  input wire logic [5:0] rx_dyn_length, // Carried length
  input wire logic [1:0] group_address_length, // Address code
  input wire logic [2:0] address_bytes, // Address bytes
  input wire logic air_rate_select, // Rate
  input wire logic checksum_enable, // CRC on
  input wire logic checksum_length, // CRC length
  input wire logic [1:0] crc_bytes, // CRC bytes
  input wire logic [7:0] pipe_ack_enable, // Ack enables
  input wire logic [7:0] pipe_varlen_enable, // Varlen enables
  input wire logic [5:0] rx_payload_length, // Length in use
  input wire logic resend_req, // Resend pulse
  input wire logic [3:0] resend_counter // Resends done
);
  default clocking cb @(posedge sys_clk); endclocking

  // No second resend inside eight cycles
  sequence s_quiet_gap;
    !resend_req [*8];
  endsequence

  a_reset_format: assert property (
    !rst_n |=> air_rate_select && checksum_enable && checksum_length)
    else $error("format outputs wrong after reset");
  a_reset_pipes: assert property (
    !rst_n |=> pipe_ack_enable == 8'h00 && pipe_varlen_enable == 8'h00 && resend_counter == 4'h0)
    else $error("pipe outputs wrong after reset");
  a_addr_bytes: assert property (disable iff (!rst_n)
    group_address_length != 2'b00 |-> address_bytes == {1'b0, group_address_length} + 3'h1)
    else $error("address bytes do not follow code");
  a_crc_bytes: assert property (disable iff (!rst_n)
    crc_bytes == (!checksum_enable ? 2'h0 : (checksum_length ? 2'h2 : 2'h1)))
    else $error("crc bytes do not follow bits");
  a_len_select: assert property (disable iff (!rst_n)
    $stable(pipe_varlen_enable) && pipe_varlen_enable[$past(rx_pipe)]
      |-> rx_payload_length == $past(rx_dyn_length))
    else $error("dynamic length not used");
  a_count_step: assert property (disable iff (!rst_n)
    resend_req |-> resend_counter == $past(resend_counter) + 4'h1)
    else $error("resend counter not stepped");
  a_req_gap: assert property (disable iff (!rst_n)
    resend_req |=> s_quiet_gap)
    else $error("resends too close");
  a_new_clears: assert property (disable iff (!rst_n)
    new_packet |-> ##[1:2] resend_counter == 4'h0)
    else $error("counter not cleared by new packet");
endmodule : rlc_props

`default_nettype wire

// File: hw/rlc_pkg.sv
package rlc_pkg;

  typedef enum logic [1:0] {
    RLC_PH_CMD = 2'b00,
    RLC_PH_DATA = 2'b01,
    RLC_PH_DONE = 2'b10
  } rlc_phase_t;

  typedef enum logic [1:0] {
    RLC_T_IDLE = 2'b00,
    RLC_T_WAIT = 2'b01
  } rlc_timer_state_t;

endpackage : rlc_pkg

// File: hw/rlc_regs.svh
`ifndef RLC_REGS_SVH
`define RLC_REGS_SVH

// Register offsets on the serial command port
`define RLC_OFS_STATUS 7'h01
`define RLC_OFS_INT_ENABLE 7'h02
`define RLC_OFS_FORMAT 7'h03
`define RLC_OFS_PIPE_RX_EN 7'h04
`define RLC_OFS_PIPE_ACK_EN 7'h05
`define RLC_OFS_PIPE_VARLEN_EN 7'h06
`define RLC_OFS_ACK_RESEND_DLY 7'h07
`define RLC_OFS_RESEND_COUNT 7'h08
`define RLC_OFS_PIPE1_LENGTH 7'h16

// Reset values
`define RLC_RST_INT_ENABLE 8'h30
`define RLC_RST_FORMAT 8'h33
`define RLC_RST_PIPE_RX_EN 8'hFF
`define RLC_RST_PIPE_ACK_EN 8'h00
`define RLC_RST_PIPE_VARLEN_EN 8'h00
`define RLC_RST_ACK_RESEND_DLY 8'h00
`define RLC_RST_MAX_RESEND 4'h0
`define RLC_RST_PIPE1_LENGTH 6'h00

// Interrupt enable fields
`define RLC_IE_POLARITY 7
`define RLC_IE_LIMIT 3
`define RLC_IE_TX_EMPTY 2
`define RLC_IE_RX_EMPTY 1
`define RLC_IE_SIG_MEAS 0
`define RLC_IE_WMASK 8'hBF

// Status fields
`define RLC_ST_LIMIT 3
`define RLC_ST_SIG_MEAS 2
`define RLC_ST_TX_EMPTY 1
`define RLC_ST_RX_NOT_EMPTY 0

// Format fields
`define RLC_FMT_ADDR_LEN_HI 6
`define RLC_FMT_ADDR_LEN_LO 5
`define RLC_FMT_RATE 4
`define RLC_FMT_POWER_HI 3
`define RLC_FMT_POWER_LO 2
`define RLC_FMT_CRC_EN 1
`define RLC_FMT_CRC_LEN 0
`define RLC_FMT_WMASK 8'h7F

// Delay and count fields
`define RLC_DLY_ACK_HI 7
`define RLC_DLY_ACK_LO 4
`define RLC_DLY_RESEND_HI 3
`define RLC_DLY_RESEND_LO 0
`define RLC_CNT_MAX_HI 7
`define RLC_CNT_MAX_LO 4

// Serial command byte
`define RLC_CMD_WRITE 7

// Timing: one delay step
`define RLC_STEP_US 250
`define RLC_CLK_MHZ 100
`define RLC_STEP_CYCLES (`RLC_STEP_US * `RLC_CLK_MHZ)

`endif

// File: hw/rlc_resend_timer.sv
`timescale 1ns/1ns
`default_nettype none

module rlc_resend_timer
  import rlc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 25000
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic new_packet, // Pulse: fresh payload, counters restart
  input wire logic tx_sent, // Pulse: packet left the air, ack awaited
  input wire logic ack_rcvd, // Pulse: acknowledgement arrived
  input wire logic limit_hold, // Limit flag still set, resends stalled
  input wire logic [3:0] ack_wait, // Ack wait delay code
  input wire logic [3:0] resend_delay, // Resend delay code
  input wire logic [3:0] max_resend, // Resend limit
  output logic resend_req, // Pulse: send the packet again
  output logic limit_evt, // Pulse: limit reached
  output logic [3:0] resend_cnt // Resends done for this packet
);

  rlc_timer_state_t state_q;
  logic [1:0] mult_q;
  logic [5:0] steps_q;
  logic [31:0] presc_q;
  wire [5:0] rsd_part = {4'b0000, mult_q} * {2'b00, resend_delay};
  wire [5:0] total_steps = 6'({2'b00, ack_wait} + 6'd1) + rsd_part;
  wire step_end = (presc_q == STEP_CYCLES - 1);
  wire timeout = step_end && (steps_q == 6'd1);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= RLC_T_IDLE;
      mult_q <= 2'd1;
      steps_q <= 6'd0;
      presc_q <= 32'd0;
      resend_req <= 1'b0;
      limit_evt <= 1'b0;
      resend_cnt <= 4'h0;
    end else begin
      resend_req <= 1'b0;
      limit_evt <= 1'b0;
      case (state_q)
        RLC_T_IDLE: begin
          if (new_packet) begin
            resend_cnt <= 4'h0;
            mult_q <= 2'd1;
          end else if (tx_sent && !limit_hold) begin
            state_q <= RLC_T_WAIT;
            steps_q <= total_steps;
            presc_q <= 32'd0;
          end
        end
        RLC_T_WAIT: begin
          if (ack_rcvd || new_packet) begin
            state_q <= RLC_T_IDLE;
            if (new_packet) begin
              resend_cnt <= 4'h0;
              mult_q <= 2'd1;
            end
          end else if (timeout) begin
            state_q <= RLC_T_IDLE;
            if (resend_cnt == max_resend) begin
              limit_evt <= 1'b1;
            end else begin
              resend_req <= 1'b1;
              resend_cnt <= resend_cnt + 4'h1;
              mult_q <= (mult_q == 2'd3) ? 2'd1 : mult_q + 2'd1;
            end
          end else if (step_end) begin
            presc_q <= 32'd0;
            steps_q <= steps_q - 6'd1;
          end else begin
            presc_q <= presc_q + 32'd1;
          end
        end
        default: begin
          state_q <= RLC_T_IDLE;
        end
      endcase
    end
  end

endmodule : rlc_resend_timer

`default_nettype wire

// File: hw/rlc_spi_slave.sv
`timescale 1ns/1ns
`default_nettype none

module rlc_spi_slave (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic spi_csn, // Chip select, active low
  input wire logic spi_sck, // Serial clock, mode 0
  input wire logic spi_mosi, // Serial data in
  input wire logic load, // Load next outgoing byte
  input wire logic [7:0] tx_byte, // Outgoing byte
  output logic spi_miso, // Serial data out
  output logic spi_miso_oe, // Drive enable for serial data out
  output logic sel_start, // Pulse at select falling
  output logic byte_done, // Pulse after eighth bit
  output logic [7:0] rx_byte // Last complete byte
);

  logic sck_q;
  logic csn_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] in_sh_q;
  logic [7:0] out_sh_q;
  wire sck_rise = spi_sck & ~sck_q & ~spi_csn;
  wire sck_fall = ~spi_sck & sck_q & ~spi_csn;
  wire csn_fall = csn_q & ~spi_csn;

  assign spi_miso = out_sh_q[7];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sck_q <= 1'b0;
      csn_q <= 1'b1;
      bit_cnt_q <= 3'd0;
      in_sh_q <= 7'h00;
      out_sh_q <= 8'h00;
      spi_miso_oe <= 1'b0;
      sel_start <= 1'b0;
      byte_done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      sck_q <= spi_sck;
      csn_q <= spi_csn;
      spi_miso_oe <= ~spi_csn;
      sel_start <= csn_fall;
      byte_done <= sck_rise & (bit_cnt_q == 3'd7);
      if (spi_csn) begin
        bit_cnt_q <= 3'd0;
      end else if (sck_rise) begin
        bit_cnt_q <= bit_cnt_q + 3'd1;
        in_sh_q <= {in_sh_q[5:0], spi_mosi};
        if (bit_cnt_q == 3'd7) begin
          rx_byte <= {in_sh_q, spi_mosi};
        end
      end
      if (load) begin
        out_sh_q <= tx_byte;
      end else if (sck_fall && bit_cnt_q != 3'd0) begin
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

endmodule : rlc_spi_slave

`default_nettype wire

// File: hw/rlc_top.sv
// What this block does
// - Transmit FIFO empty raises the interrupt when enable bit 2 is set.
// - Receive FIFO empty raises the interrupt when enable bit 1 is set.
// - Finished signal-strength update raises the interrupt when enable bit 0 set.
// - Address length field 6:5 gives 2, 3, 4 bytes; code 00 forbidden.
// - Rate bit 4, reset 1: clear 250 kbps, set 2 Mbps.
// - Power field 3:2 picks -20, -14, -8, 0 dBm.
// - Checksum enable bit 1, reset 1, adds and checks packet CRC.
// - Checksum length bit 0, reset 1: clear one byte, set two.
// - Eight per-pipe auto-acknowledge enables, bit n-1 for pipe n, reset 0.
// - Eight per-pipe dynamic length enables, bit n-1 for pipe n, reset 0.
// - Ack wait field 7:4 waits (code+1) steps of 250 us.
// - Each resend waits ack wait plus cycling multiple of resend delay.
// - Resend delay multiple cycles 1, 2, 3, then repeats.
// - Resend delay in 250 us steps; code 0000 adds nothing.
// - Field 7:4, reset 0000, caps automatic resends per packet.
// - Reaching the cap sets limit flag, cleared by writing 1.
// - Pipe without dynamic length uses a fixed length: pipe 1 its programmed one, pipes 2 to 8 rx_other_fixed_length.
// - Interrupt pin active low if polarity bit 7 is 0, else high.
`timescale 1ns/1ns
`default_nettype none
`include "rlc_regs.svh"

module rlc_top
  import rlc_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `RLC_STEP_CYCLES
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic spi_csn, // Command port select, active low
  input wire logic spi_sck, // Command port clock
  input wire logic spi_mosi, // Command port data in
  output logic spi_miso, // Command port data out
  output logic spi_miso_oe, // Data out drive enable
  input wire logic tx_fifo_empty, // Transmit FIFO holds nothing
  input wire logic rx_fifo_empty, // Receive FIFO holds nothing
  input wire logic sig_meas_done, // Pulse: signal-strength update done
  input wire logic new_packet, // Pulse: new payload loaded for send
  input wire logic tx_sent, // Pulse: packet sent, ack awaited
  input wire logic ack_rcvd, // Pulse: ack received
  input wire logic [2:0] rx_pipe, // Pipe of current receive, 0 is pipe 1
  input wire logic [5:0] rx_dyn_length, // Length carried in the packet
  input wire logic [5:0] rx_other_fixed_length, // Fixed length, pipes 2 to 8
  output logic int_pin, // Interrupt pin
  output logic [1:0] group_address_length, // Address length code
  output logic [2:0] address_bytes, // Address bytes, 0 when code invalid
  output logic air_rate_select, // 1: 2 Mbps, 0: 250 kbps
  output logic [1:0] output_power_level, // Transmit power code
  output logic checksum_enable, // Packet CRC on
  output logic checksum_length, // 1: two-byte CRC
  output logic [1:0] crc_bytes, // CRC bytes on air, 0 when off
  output logic [7:0] pipe_rx_enable, // Receive enable per pipe
  output logic [7:0] pipe_ack_enable, // Auto-ack enable per pipe
  output logic [7:0] pipe_varlen_enable, // Dynamic length enable per pipe
  output logic [5:0] rx_payload_length, // Length in use for current pipe
  output logic resend_req, // Pulse: resend the packet
  output logic [3:0] resend_counter // Resends for this packet
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] int_enable_ctrl_q;
  logic [7:0] radio_format_config_q;
  logic [7:0] pipe_receive_enable_q;
  logic [7:0] pipe_auto_ack_enable_q;
  logic [7:0] pipe_dynamic_length_enable_q;
  logic [7:0] ack_and_resend_delay_q;
  logic [3:0] max_resend_count_q;
  logic [5:0] pipe1_fixed_length_q;

  logic resend_limit_flag_q;
  logic sig_meas_flag_q;

  rlc_phase_t phase_q;
  logic cmd_write_q;
  logic [6:0] cmd_addr_q;
  logic load_q;
  logic [7:0] load_byte_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command port
  logic sel_start;
  logic byte_done;
  logic [7:0] rx_byte;

  logic limit_evt;

  rlc_spi_slave u_spi (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .spi_csn(spi_csn),
    .spi_sck(spi_sck),
    .spi_mosi(spi_mosi),
    .load(load_q),
    .tx_byte(load_byte_q),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe),
    .sel_start(sel_start),
    .byte_done(byte_done),
    .rx_byte(rx_byte)
  );

  wire [7:0] status_byte = {4'h0, resend_limit_flag_q, sig_meas_flag_q,
                            tx_fifo_empty, ~rx_fifo_empty};

  wire cmd_taken = byte_done && (phase_q == RLC_PH_CMD);
  wire data_taken = byte_done && (phase_q == RLC_PH_DATA);

  // Write strobes
  wire wr_en = data_taken && cmd_write_q;
  wire wr_status = wr_en && (cmd_addr_q == `RLC_OFS_STATUS);
  wire wr_ie = wr_en && (cmd_addr_q == `RLC_OFS_INT_ENABLE);
  wire wr_fmt = wr_en && (cmd_addr_q == `RLC_OFS_FORMAT);
  wire wr_rxen = wr_en && (cmd_addr_q == `RLC_OFS_PIPE_RX_EN);
  wire wr_ack = wr_en && (cmd_addr_q == `RLC_OFS_PIPE_ACK_EN);
  wire wr_varlen = wr_en && (cmd_addr_q == `RLC_OFS_PIPE_VARLEN_EN);
  wire wr_dly = wr_en && (cmd_addr_q == `RLC_OFS_ACK_RESEND_DLY);
  wire wr_cnt = wr_en && (cmd_addr_q == `RLC_OFS_RESEND_COUNT);
  wire wr_len = wr_en && (cmd_addr_q == `RLC_OFS_PIPE1_LENGTH);

  // Write-1-to-clear status bits
  wire clr_limit = wr_status && rx_byte[`RLC_ST_LIMIT];
  wire clr_sig = wr_status && rx_byte[`RLC_ST_SIG_MEAS];

  logic [7:0] rd_data;
  always_comb begin
    case (rx_byte[6:0])
      `RLC_OFS_STATUS: rd_data = status_byte;
      `RLC_OFS_INT_ENABLE: rd_data = int_enable_ctrl_q;
      `RLC_OFS_FORMAT: rd_data = radio_format_config_q;
      `RLC_OFS_PIPE_RX_EN: rd_data = pipe_receive_enable_q;
      `RLC_OFS_PIPE_ACK_EN: rd_data = pipe_auto_ack_enable_q;
      `RLC_OFS_PIPE_VARLEN_EN: rd_data = pipe_dynamic_length_enable_q;
      `RLC_OFS_ACK_RESEND_DLY: rd_data = ack_and_resend_delay_q;
      `RLC_OFS_RESEND_COUNT: rd_data = {max_resend_count_q, resend_counter};
      `RLC_OFS_PIPE1_LENGTH: rd_data = {2'b00, pipe1_fixed_length_q};
      default: rd_data = 8'h00;
    endcase
  end

  // Phase tracking, one register per select
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_q <= RLC_PH_CMD;
      cmd_write_q <= 1'b0;
      cmd_addr_q <= 7'h00;
      load_q <= 1'b0;
      load_byte_q <= 8'h00;
    end else begin
      load_q <= sel_start | cmd_taken;
      load_byte_q <= sel_start ? status_byte : rd_data;
      if (spi_csn) begin
        phase_q <= RLC_PH_CMD;
      end else if (cmd_taken) begin
        phase_q <= RLC_PH_DATA;
        cmd_write_q <= rx_byte[`RLC_CMD_WRITE];
        cmd_addr_q <= rx_byte[6:0];
      end else if (data_taken) begin
        phase_q <= RLC_PH_DONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration storage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_enable_ctrl_q <= `RLC_RST_INT_ENABLE;
      radio_format_config_q <= `RLC_RST_FORMAT;
      pipe_receive_enable_q <= `RLC_RST_PIPE_RX_EN;
      pipe_auto_ack_enable_q <= `RLC_RST_PIPE_ACK_EN;
      pipe_dynamic_length_enable_q <= `RLC_RST_PIPE_VARLEN_EN;
      ack_and_resend_delay_q <= `RLC_RST_ACK_RESEND_DLY;
      max_resend_count_q <= `RLC_RST_MAX_RESEND;
      pipe1_fixed_length_q <= `RLC_RST_PIPE1_LENGTH;
    end else begin
      if (wr_ie) begin
        int_enable_ctrl_q <= rx_byte & `RLC_IE_WMASK;
      end
      if (wr_fmt) begin
        radio_format_config_q <= rx_byte & `RLC_FMT_WMASK;
      end
      if (wr_rxen) begin
        pipe_receive_enable_q <= rx_byte;
      end
      if (wr_ack) begin
        pipe_auto_ack_enable_q <= rx_byte;
      end
      if (wr_varlen) begin
        pipe_dynamic_length_enable_q <= rx_byte;
      end
      if (wr_dly) begin
        ack_and_resend_delay_q <= rx_byte;
      end
      if (wr_cnt) begin
        max_resend_count_q <= rx_byte[`RLC_CNT_MAX_HI:`RLC_CNT_MAX_LO];
      end
      if (wr_len) begin
        pipe1_fixed_length_q <= rx_byte[5:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, a set beats a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      resend_limit_flag_q <= 1'b0;
      sig_meas_flag_q <= 1'b0;
    end else begin
      if (limit_evt) begin
        resend_limit_flag_q <= 1'b1;
      end else if (clr_limit) begin
        resend_limit_flag_q <= 1'b0;
      end
      if (sig_meas_done) begin
        sig_meas_flag_q <= 1'b1;
      end else if (clr_sig) begin
        sig_meas_flag_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resend timing
  rlc_resend_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .new_packet(new_packet),
    .tx_sent(tx_sent),
    .ack_rcvd(ack_rcvd),
    .limit_hold(resend_limit_flag_q),
    .ack_wait(ack_and_resend_delay_q[`RLC_DLY_ACK_HI:`RLC_DLY_ACK_LO]),
    .resend_delay(ack_and_resend_delay_q[`RLC_DLY_RESEND_HI:`RLC_DLY_RESEND_LO]),
    .max_resend(max_resend_count_q),
    .resend_req(resend_req),
    .limit_evt(limit_evt),
    .resend_cnt(resend_counter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin
  wire pend_tx = int_enable_ctrl_q[`RLC_IE_TX_EMPTY] & tx_fifo_empty;
  wire pend_rx = int_enable_ctrl_q[`RLC_IE_RX_EMPTY] & rx_fifo_empty;
  wire pend_sig = int_enable_ctrl_q[`RLC_IE_SIG_MEAS] & sig_meas_flag_q;
  wire pend_lim = int_enable_ctrl_q[`RLC_IE_LIMIT] & resend_limit_flag_q;

  wire int_pending = pend_tx | pend_rx | pend_sig | pend_lim;
  wire int_polarity = int_enable_ctrl_q[`RLC_IE_POLARITY];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      int_pin <= 1'b1;
    end else begin
      int_pin <= int_polarity ? int_pending : ~int_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded configuration
  wire [1:0] addr_code = radio_format_config_q[`RLC_FMT_ADDR_LEN_HI:`RLC_FMT_ADDR_LEN_LO];
  wire crc_on = radio_format_config_q[`RLC_FMT_CRC_EN];
  wire crc_two = radio_format_config_q[`RLC_FMT_CRC_LEN];

  // Payload length source
  wire pipe_varlen = pipe_dynamic_length_enable_q[rx_pipe];
  wire [5:0] fixed_len = (rx_pipe == 3'd0) ? pipe1_fixed_length_q : rx_other_fixed_length;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      group_address_length <= 2'b01;
      address_bytes <= 3'd2;
      air_rate_select <= 1'b1;
      output_power_level <= 2'b00;
      checksum_enable <= 1'b1;
      checksum_length <= 1'b1;
      crc_bytes <= 2'd2;
      pipe_rx_enable <= 8'hFF;
      pipe_ack_enable <= 8'h00;
      pipe_varlen_enable <= 8'h00;
      rx_payload_length <= 6'd0;
    end else begin
      group_address_length <= addr_code;
      address_bytes <= (addr_code == 2'b00) ? 3'd0 : 3'({1'b0, addr_code} + 3'd1);
      air_rate_select <= radio_format_config_q[`RLC_FMT_RATE];
      output_power_level <= radio_format_config_q[`RLC_FMT_POWER_HI:`RLC_FMT_POWER_LO];
      checksum_enable <= crc_on;
      checksum_length <= crc_two;
      crc_bytes <= !crc_on ? 2'd0 : (crc_two ? 2'd2 : 2'd1);
      pipe_rx_enable <= pipe_receive_enable_q;
      pipe_ack_enable <= pipe_auto_ack_enable_q;
      pipe_varlen_enable <= pipe_dynamic_length_enable_q;
      rx_payload_length <= pipe_varlen ? rx_dyn_length : fixed_len;
    end
  end

endmodule : rlc_top

`default_nettype wire
